//--- design/pio_pkg.sv
// Purpose: shared constants and types of the parallel i/o and event port
// Assumes: classic wishbone slave, 32-bit data, byte addresses
// Notes:   one aligned word per register, unused upper bits read zero
package pio_pkg;

  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADR_W  = 8;

  // register byte offsets
  localparam logic [7:0] OFF_DIR     = 8'h00;
  localparam logic [7:0] OFF_OUT     = 8'h04;
  localparam logic [7:0] OFF_CMD     = 8'h08;
  localparam logic [7:0] OFF_CAPT    = 8'h0C;
  localparam logic [7:0] OFF_EVT     = 8'h10;
  localparam logic [7:0] OFF_HWSTAT  = 8'h14;
  localparam logic [7:0] OFF_SUMMARY = 8'h18;

  // command register fields
  localparam int unsigned CMD_SEND_BIT   = 0;
  localparam int unsigned CMD_SAMPLE_BIT = 1;
  localparam int unsigned CMD_POL_BIT    = 2;
  localparam int unsigned CMD_BUSY_BIT   = 3;

  // event register fields (write: arm/disarm, read: armed/tripped)
  localparam int unsigned EVT_ARM_A_BIT    = 0;
  localparam int unsigned EVT_ARM_B_BIT    = 1;
  localparam int unsigned EVT_DISARM_A_BIT = 2;
  localparam int unsigned EVT_DISARM_B_BIT = 3;
  localparam int unsigned EVT_ARMED_A_BIT  = 0;
  localparam int unsigned EVT_ARMED_B_BIT  = 1;
  localparam int unsigned EVT_TRIP_A_BIT   = 2;
  localparam int unsigned EVT_TRIP_B_BIT   = 3;

  // hardware condition group and summary
  localparam int unsigned HW_A_BIT   = 13;
  localparam int unsigned HW_B_BIT   = 14;
  localparam int unsigned SUM_HW_BIT = 5;

  // reset values
  localparam logic [15:0] DIR_RST = 16'h0000;
  localparam logic [15:0] OUT_RST = 16'h0000;
  localparam logic        POL_RST = 1'b1;

  // timing
  localparam int unsigned CLK_HZ      = 25000000;
  localparam int unsigned OUT_RATE_HZ = 200000;
  localparam int unsigned IN_RATE_HZ  = 50000;
  localparam int unsigned WORD_CYCLES = CLK_HZ / OUT_RATE_HZ;
  localparam int unsigned STROBE_LEN  = 2;

  typedef enum logic [1:0] {
    EVT_DISARMED = 2'b00,
    EVT_ARMED    = 2'b01,
    EVT_TRIPPED  = 2'b11
  } evt_state_t;

endpackage

//--- design/event_if.sv
// Purpose: carrier between the port core and one event input unit
// Assumes: all signals on core_clk
// Notes:   requests are one-cycle pulses, status is level
`timescale 1ns/10ps
interface event_if;
  logic arm_req;
  logic disarm_req;
  logic pin_low;
  logic armed;
  logic tripped;

  modport ctl  (output arm_req, output disarm_req, output pin_low,
                input armed, input tripped);
  modport unit (input arm_req, input disarm_req, input pin_low,
                output armed, output tripped);
endinterface

//--- design/event_input.sv
// Purpose: one armable low-level event input
// Assumes: pin level already synchronous to core_clk
// Notes:   a trip in the same cycle as a disarm wins
`timescale 1ns/10ps
module event_input (
  // clock and reset
  input wire logic   core_clk,
  input wire logic   rst_n,
  // core side
  event_if.unit      ev
);

  pio_pkg::evt_state_t state_q;
  pio_pkg::evt_state_t state_d;

  always_comb begin
    state_d = state_q;
    case (state_q)
      pio_pkg::EVT_DISARMED: begin
        if (ev.arm_req && !ev.disarm_req) begin // RULE18
          state_d = pio_pkg::EVT_ARMED;
        end
      end
      pio_pkg::EVT_ARMED: begin
        if (ev.pin_low) begin // RULE12
          state_d = pio_pkg::EVT_TRIPPED;
        end else if (ev.disarm_req) begin
          state_d = pio_pkg::EVT_DISARMED;
        end
      end
      pio_pkg::EVT_TRIPPED: begin
        // arm alone is ignored here, only a disarm leaves
        if (ev.disarm_req) begin // RULE13
          state_d = pio_pkg::EVT_DISARMED;
        end
      end
      default: state_d = pio_pkg::EVT_DISARMED;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= pio_pkg::EVT_DISARMED; // RULE22
    end else begin
      state_q <= state_d;
    end
  end

  assign ev.armed   = (state_q == pio_pkg::EVT_ARMED);
  assign ev.tripped = (state_q == pio_pkg::EVT_TRIPPED);

  a_trip_on_low: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE12
    (state_q == pio_pkg::EVT_ARMED) && ev.pin_low |=> state_q == pio_pkg::EVT_TRIPPED)
    else $error("armed input did not trip on low");

  a_trip_sticky: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE13
    (state_q == pio_pkg::EVT_TRIPPED) && !ev.disarm_req |=> state_q == pio_pkg::EVT_TRIPPED)
    else $error("tripped input left without disarm");

  a_disarmed_deaf: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE18
    (state_q == pio_pkg::EVT_DISARMED) && !ev.arm_req |=> state_q == pio_pkg::EVT_DISARMED)
    else $error("disarmed input changed state");

endmodule // event_input

//--- design/parallel_io_interrupt_port.sv
// Purpose: 16-line open-collector parallel port with strobe and two event inputs
// Assumes: classic wishbone slave, all pins synchronous to core_clk (25 MHz)
// Notes:   line driver only ever pulls low; oe_n high means released
//
// The register offsets and the Wishbone slave port were decided locally.
`timescale 1ns/10ps

// What this block does
// RULE1 - a line whose direction bit is one is released high, acting as input
// RULE2 - sample command captures all sixteen line levels, outputs included
// RULE3 - captured value changes only on sample, reads return the latched copy
// RULE4 - effective bit zero pulls the line low, one releases it
// RULE5 - effective bit is direction OR latched output, direction acts at once
// RULE6 - writing output value leaves pins alone until a send command
// RULE7 - each send pulses the strobe with programmable polarity as data changes
// RULE8 - receiver should latch on strobe trailing edge or level
// RULE9 - operator knob steps the output value up or down while selected
// RULE10 - far side keeps input changes below about 50 kHz
// RULE11 - successive output words can be presented at about 200 Kb/s
// RULE12 - an armed event input trips on a low level
// RULE13 - tripped stays tripped until disarmed and then armed again
// RULE14 - a trip sets a hardware condition bit that software can poll
// RULE15 - direction value is taken as a binary word, 255 makes low eight inputs
// RULE16 - with outputs zero and no line low, capture returns mask ones
// RULE17 - output word followed by send appears on the lines
// RULE18 - separate arm and disarm, a disarmed input ignores its pin
// RULE19 - event a maps to condition bit 13, event b to bit 14, summarised
// RULE20 - the two event inputs are independent and usable together
// RULE21 - bit zero is the lowest data line, bit fifteen the highest
// RULE22 - reset clears mask, output, events, strobe rests inactive
// RULE23 - strobe lasts a fixed cycle count and starts with the new data
module parallel_io_interrupt_port #(
  parameter int unsigned STROBE_CYCLES = pio_pkg::STROBE_LEN
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic             wb_ack_o,
  output logic [31:0]      wb_dat_o,
  // parallel data lines
  input  wire logic [15:0] data_in,
  output logic [15:0]      data_out,
  output logic [15:0]      data_oe_n,
  output logic             strobe_out,
  // event inputs, active low
  input  wire logic [1:0]  event_pin_n,
  // operator knob
  input  wire logic        knob_sel,
  input  wire logic        knob_up,
  input  wire logic        knob_dn
);

  localparam int unsigned CNT_W = $clog2(STROBE_CYCLES + 1);
  localparam logic [CNT_W-1:0] STROBE_LOAD = CNT_W'(STROBE_CYCLES);

  generate
    if (STROBE_CYCLES < 1 || STROBE_CYCLES >= pio_pkg::WORD_CYCLES) begin : g_bad_strobe
      $error("STROBE_CYCLES must be at least 1 and below one word period"); // RULE11
    end
  endgenerate

  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [15:0] new_v,
                                          input logic [1:0]  sel);
    merge16 = {sel[1] ? new_v[15:8] : old_v[15:8], sel[0] ? new_v[7:0] : old_v[7:0]};
  endfunction

  // bus state
  logic        ack_q;
  logic        ack_d;
  logic [31:0] rdat_q;
  logic [31:0] rdat_d;
  // port state
  logic [15:0] dir_q;
  logic [15:0] dir_d;
  logic [15:0] outv_q;
  logic [15:0] outv_d;
  logic [15:0] latch_q;
  logic [15:0] latch_d;
  logic [15:0] capt_q;
  logic [15:0] capt_d;
  logic [15:0] oe_n_q;
  logic [15:0] oe_n_d;
  logic        pol_q;
  logic        pol_d;
  logic [CNT_W-1:0] strb_cnt_q;
  logic [CNT_W-1:0] strb_cnt_d;
  logic        strobe_q;
  logic        strobe_d;

  logic [7:0]  adr;
  logic        wr;
  logic        wr_dir;
  logic        wr_out;
  logic        wr_cmd;
  logic        wr_evt;
  logic        send;
  logic        sample;
  logic [15:0] hwstat;

  event_if ev_a ();
  event_if ev_b ();

  assign adr    = {wb_adr_i[7:2], 2'b00};
  // a write lands on the edge where the master sees ack
  assign wr     = wb_cyc_i && wb_stb_i && wb_we_i && ack_q;
  assign wr_dir = wr && (adr == pio_pkg::OFF_DIR);
  assign wr_out = wr && (adr == pio_pkg::OFF_OUT);
  assign wr_cmd = wr && (adr == pio_pkg::OFF_CMD) && wb_sel_i[0];
  assign wr_evt = wr && (adr == pio_pkg::OFF_EVT) && wb_sel_i[0];
  assign send   = wr_cmd && wb_dat_i[pio_pkg::CMD_SEND_BIT];
  assign sample = wr_cmd && wb_dat_i[pio_pkg::CMD_SAMPLE_BIT];

  // event control, both units run side by side
  assign ev_a.arm_req    = wr_evt && wb_dat_i[pio_pkg::EVT_ARM_A_BIT];    // RULE18
  assign ev_a.disarm_req = wr_evt && wb_dat_i[pio_pkg::EVT_DISARM_A_BIT];
  assign ev_a.pin_low    = !event_pin_n[0];
  assign ev_b.arm_req    = wr_evt && wb_dat_i[pio_pkg::EVT_ARM_B_BIT];
  assign ev_b.disarm_req = wr_evt && wb_dat_i[pio_pkg::EVT_DISARM_B_BIT];
  assign ev_b.pin_low    = !event_pin_n[1];

  event_input u_event_a ( // RULE20
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .ev       (ev_a.unit)
  );

  event_input u_event_b (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .ev       (ev_b.unit)
  );

  always_comb begin
    hwstat = 16'h0000;
    hwstat[pio_pkg::HW_A_BIT] = ev_a.tripped; // RULE14 RULE19
    hwstat[pio_pkg::HW_B_BIT] = ev_b.tripped;
  end

  // port datapath
  always_comb begin
    dir_d = dir_q;
    if (wr_dir) begin
      dir_d = merge16(dir_q, wb_dat_i[15:0], wb_sel_i[1:0]); // RULE15 RULE21
    end
    outv_d = outv_q;
    if (wr_out) begin
      outv_d = merge16(outv_q, wb_dat_i[15:0], wb_sel_i[1:0]);
    end else if (knob_sel && (knob_up != knob_dn)) begin
      // bus write wins over a knob step in the same cycle
      outv_d = knob_up ? outv_q + 16'h0001 : outv_q - 16'h0001; // RULE9
    end
    latch_d = send ? outv_q : latch_q; // RULE6 RULE17
    capt_d  = sample ? data_in : capt_q; // RULE2 RULE3 RULE16
    pol_d   = wr_cmd ? wb_dat_i[pio_pkg::CMD_POL_BIT] : pol_q;
    oe_n_d  = dir_d | latch_d; // RULE1 RULE4 RULE5
  end

  // strobe: a send during a pulse restarts it
  always_comb begin
    if (send) begin
      strb_cnt_d = STROBE_LOAD; // RULE23
    end else if (strb_cnt_q != '0) begin
      strb_cnt_d = strb_cnt_q - CNT_W'(1);
    end else begin
      strb_cnt_d = '0;
    end
    strobe_d = (strb_cnt_d != '0) ? pol_d : !pol_d; // RULE7
  end

  // wishbone answer, one cycle after the request
  always_comb begin
    ack_d  = wb_cyc_i && wb_stb_i && !ack_q;
    rdat_d = 32'h0000_0000;
    if (ack_d && !wb_we_i) begin
      case (adr)
        pio_pkg::OFF_DIR:  rdat_d[15:0] = dir_q;
        pio_pkg::OFF_OUT:  rdat_d[15:0] = outv_q;
        pio_pkg::OFF_CMD: begin
          rdat_d[pio_pkg::CMD_POL_BIT]  = pol_q;
          rdat_d[pio_pkg::CMD_BUSY_BIT] = (strb_cnt_q != '0);
        end
        pio_pkg::OFF_CAPT: rdat_d[15:0] = capt_q; // RULE3
        pio_pkg::OFF_EVT: begin
          rdat_d[pio_pkg::EVT_ARMED_A_BIT] = ev_a.armed;
          rdat_d[pio_pkg::EVT_ARMED_B_BIT] = ev_b.armed;
          rdat_d[pio_pkg::EVT_TRIP_A_BIT]  = ev_a.tripped;
          rdat_d[pio_pkg::EVT_TRIP_B_BIT]  = ev_b.tripped;
        end
        pio_pkg::OFF_HWSTAT:  rdat_d[15:0] = hwstat; // RULE14
        pio_pkg::OFF_SUMMARY: rdat_d[pio_pkg::SUM_HW_BIT] = |hwstat; // RULE19
        default: rdat_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_q      <= 1'b0;
      rdat_q     <= 32'h0000_0000;
      dir_q      <= pio_pkg::DIR_RST; // RULE22
      outv_q     <= pio_pkg::OUT_RST;
      latch_q    <= pio_pkg::OUT_RST;
      capt_q     <= 16'h0000;
      oe_n_q     <= pio_pkg::DIR_RST | pio_pkg::OUT_RST;
      pol_q      <= pio_pkg::POL_RST;
      strb_cnt_q <= '0;
      strobe_q   <= !pio_pkg::POL_RST;
    end else begin
      ack_q      <= ack_d;
      rdat_q     <= rdat_d;
      dir_q      <= dir_d;
      outv_q     <= outv_d;
      latch_q    <= latch_d;
      capt_q     <= capt_d;
      oe_n_q     <= oe_n_d;
      pol_q      <= pol_d;
      strb_cnt_q <= strb_cnt_d;
      strobe_q   <= strobe_d;
    end
  end

  assign wb_ack_o   = ack_q;
  assign wb_dat_o   = rdat_q;
  assign data_oe_n  = oe_n_q;
  // open collector: the driven level is always low
  assign data_out   = 16'h0000; // RULE4
  assign strobe_out = strobe_q;

  a_mask_releases: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE1
    (data_oe_n & dir_q) == dir_q)
    else $error("masked line is being driven low");

  a_send_drives: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE17
    send && !wr_dir |=> data_oe_n == ($past(dir_q) | $past(outv_q)))
    else $error("send did not put output word on lines");

  a_pins_hold: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE6
    !send && !wr_dir |=> $stable(data_oe_n))
    else $error("lines changed without send or mask write");

  a_dir_immediate: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE5
    wr_dir && !send |=> data_oe_n == ($past(dir_d) | $past(latch_q)))
    else $error("mask write did not reach drivers at once");

  a_strobe_start: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE7
    send |=> strobe_out == pol_q && strb_cnt_q == STROBE_LOAD
         && data_oe_n == ($past(dir_d) | $past(outv_q)))
    else $error("strobe not active with new data");

  a_strobe_idle: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE23
    (strb_cnt_q == '0) |-> strobe_out == !pol_q)
    else $error("strobe active outside its pulse");

  a_capture_all: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE2
    sample |=> capt_q == $past(data_in))
    else $error("capture missed line levels");

  a_capture_holds: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE3
    !sample |=> $stable(capt_q))
    else $error("captured value changed without sample");

  a_knob_up: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE9
    knob_sel && knob_up && !knob_dn && !wr_out |=> outv_q == $past(outv_q) + 16'h0001)
    else $error("knob step up lost");

  a_ack_single: assert property (@(posedge core_clk) disable iff (!rst_n)
    wb_cyc_i && wb_stb_i && !ack_q |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single cycle");

  a_strobe_active: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE7
    (strb_cnt_q != '0) |-> strobe_out == pol_q)
    else $error("strobe inactive inside its pulse");

  a_strobe_ends: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE23
    (strb_cnt_q == CNT_W'(1)) && !send |=> strobe_out == !pol_q)
    else $error("strobe pulse too long");

  a_knob_down: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE9
    knob_sel && knob_dn && !knob_up && !wr_out |=> outv_q == $past(outv_q) - 16'h0001)
    else $error("knob step down lost");

  a_dat_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
    !wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data shown outside ack");

  a_trip_cause_b: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE20
    $rose(ev_b.tripped) |-> $past(ev_b.armed) && $past(ev_b.pin_low))
    else $error("event b tripped without armed low pin");

  a_disarm_leaves: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE13
    ev_a.tripped && ev_a.disarm_req |=> !ev_a.tripped && !ev_a.armed)
    else $error("disarm did not clear tripped event a");

  a_hwstat_read: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE14
    wb_ack_o && !$past(wb_we_i) && $past(adr) == pio_pkg::OFF_HWSTAT
      |-> wb_dat_o[15:0] == $past(hwstat))
    else $error("condition group read wrong");

  a_summary_read: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE19
    wb_ack_o && !$past(wb_we_i) && $past(adr) == pio_pkg::OFF_SUMMARY
      |-> wb_dat_o[pio_pkg::SUM_HW_BIT] == ($past(ev_a.tripped) || $past(ev_b.tripped)))
    else $error("summary bit does not follow trips");

endmodule // parallel_io_interrupt_port

//--- bench/far_side_model.sv
// Purpose: device under test on the far side of the parallel lines
// Assumes: pull-up on every line, external party only ever pulls low
// Notes:   latches the word on the strobe trailing edge
`timescale 1ns/10ps
module far_side_model (
  // clock
  input  wire logic        core_clk,
  // port side
  input  wire logic [15:0] data_out,
  input  wire logic [15:0] data_oe_n,
  input  wire logic        strobe_out,
  // bench control
  input  wire logic [15:0] ext_low,
  input  wire logic        strobe_pol,
  // observed
  output logic [15:0]      data_in,
  output logic [15:0]      latched
);
  logic strobe_prev_q;

  // wired and: released line floats to pull-up unless someone sinks it
  assign data_in = (data_oe_n | data_out) & ~ext_low;

  // capture once the strobe returns to rest, data has settled
  always @(posedge core_clk) begin
    strobe_prev_q <= strobe_out;
    if (strobe_prev_q == strobe_pol && strobe_out != strobe_pol) begin
      latched <= data_in;
    end
  end
endmodule // far_side_model

//--- bench/test_parallel_io_interrupt_port.sv
// Purpose: self-checking bench of the parallel port and event inputs
// Assumes: one ack per request, strobe length set to 3 here
// Notes:   reads of event state mask off the armed bits, except the reset and re-arm reads, which check all bits
`timescale 1ns/10ps
module test_parallel_io_interrupt_port;
  localparam int unsigned SC = 3;
  logic core_clk = 1'b0, rst_n = 1'b0;
  logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
  logic [7:0]  wb_adr = 8'h00;
  logic [31:0] wb_wdat = 32'h00000000, wb_dat_o, rdv;
  logic [3:0]  wb_sel = 4'h0;
  logic        wb_ack_o, strobe_out, strobe_pol = 1'b1;
  logic [15:0] data_in, data_out, data_oe_n, latched, ext_low = 16'h0000;
  logic [1:0]  event_pin_n = 2'h3;
  logic        knob_sel = 1'b0, knob_up = 1'b0, knob_dn = 1'b0;
  int          failures = 0, checks_done = 0, cycles = 0, cnt;

  always #20 core_clk = ~core_clk;

  parallel_io_interrupt_port #(.STROBE_CYCLES(SC)) i_parallel_io_interrupt_port (
    .core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_dat_i(wb_wdat), .wb_sel_i(wb_sel),
    .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .data_in(data_in),
    .data_out(data_out), .data_oe_n(data_oe_n), .strobe_out(strobe_out),
    .event_pin_n(event_pin_n), .knob_sel(knob_sel), .knob_up(knob_up),
    .knob_dn(knob_dn));

  far_side_model i_far_side_model (
    .core_clk(core_clk), .data_out(data_out), .data_oe_n(data_oe_n),
    .strobe_out(strobe_out), .ext_low(ext_low), .strobe_pol(strobe_pol),
    .data_in(data_in), .latched(latched));

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // hang guard, generous against the roughly 190 cycles of traffic
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures = failures + 1;
      complete_run();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // classic single cycle, held until ack is sampled high
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_wdat <= d;
    wb_sel <= 4'hF;
    do begin
      @(posedge core_clk);
      n = n + 1;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      failures = failures + 1;
    end
    rdv = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] adr, input logic [31:0] mask,
                        input logic [31:0] exp);
    wb(1'b0, adr, 32'h00000000);
    chk(rdv & mask, exp);
  endtask

  task automatic test_reset;
    tick(1);
    chk({16'h0000, data_oe_n}, 32'h00000000);
    chk({31'h0, strobe_out}, 32'h00000000);
    rd_chk(pio_pkg::OFF_DIR, 32'hFFFFFFFF, 32'h00000000);
    rd_chk(pio_pkg::OFF_OUT, 32'hFFFFFFFF, 32'h00000000);
    rd_chk(pio_pkg::OFF_EVT, 32'hFFFFFFFF, 32'h00000000);
    $display("test reset done");
  endtask

  task automatic test_capture;
    wb(1'b1, pio_pkg::OFF_DIR, 32'h000000FF);
    tick(2);
    chk({16'h0000, data_oe_n}, 32'h000000FF);
    @(posedge core_clk);
    ext_low <= 16'h0005;
    tick(4);
    wb(1'b1, pio_pkg::OFF_CMD, 32'h00000006);
    rd_chk(pio_pkg::OFF_CAPT, 32'hFFFFFFFF, 32'h000000FA);
    @(posedge core_clk);
    ext_low <= 16'h0000;
    tick(4);
    rd_chk(pio_pkg::OFF_CAPT, 32'hFFFFFFFF, 32'h000000FA);
    wb(1'b1, pio_pkg::OFF_CMD, 32'h00000006);
    rd_chk(pio_pkg::OFF_CAPT, 32'hFFFFFFFF, 32'h000000FF);
    wb(1'b1, pio_pkg::OFF_CAPT, 32'h00001234);
    rd_chk(pio_pkg::OFF_CAPT, 32'hFFFFFFFF, 32'h000000FF);
    $display("test capture done");
  endtask

  task automatic test_send;
    logic p;
    logic [15:0] w;
    wb(1'b1, pio_pkg::OFF_DIR, 32'h00000000);
    wb(1'b1, pio_pkg::OFF_OUT, 32'h0000FF00);
    tick(3);
    chk({16'h0000, data_oe_n}, 32'h00000000);
    for (int i = 0; i < 2; i++) begin
      p = (i == 0);
      w = p ? 16'hFF00 : 16'h00A5;
      @(posedge core_clk);
      strobe_pol <= p;
      wb(1'b1, pio_pkg::OFF_OUT, {16'h0000, w});
      wb(1'b1, pio_pkg::OFF_CMD, {29'h0, p, 2'b00});
      tick(2);
      chk({31'h0, strobe_out}, {31'h0, ~p});
      wb(1'b1, pio_pkg::OFF_CMD, {29'h0, p, 2'b01});
      // pulse starts at the ack edge itself, so look before the next edge
      #1;
      cnt = 0;
      repeat (10) begin
        if (strobe_out === p) begin
          cnt = cnt + 1;
          if (cnt == 1) chk({16'h0000, data_oe_n}, {16'h0000, w});
        end
        tick(1);
      end
      chk(cnt, SC);
      chk({16'h0000, latched}, {16'h0000, w});
    end
    wb(1'b1, pio_pkg::OFF_DIR, 32'h0000000F);
    tick(2);
    chk({16'h0000, data_oe_n}, 32'h000000AF);
    $display("test send done");
  endtask

  task automatic test_events;
    wb(1'b1, pio_pkg::OFF_EVT, 32'h00000001);
    @(posedge core_clk);
    event_pin_n <= 2'b01;
    tick(3);
    rd_chk(pio_pkg::OFF_EVT, 32'h0000000C, 32'h00000000);
    @(posedge core_clk);
    event_pin_n <= 2'b00;
    tick(3);
    rd_chk(pio_pkg::OFF_EVT, 32'h0000000C, 32'h00000004);
    rd_chk(pio_pkg::OFF_HWSTAT, 32'hFFFFFFFF, 32'h00002000);
    rd_chk(pio_pkg::OFF_SUMMARY, 32'hFFFFFFFF, 32'h00000020);
    @(posedge core_clk);
    event_pin_n <= 2'b11;
    wb(1'b1, pio_pkg::OFF_EVT, 32'h00000001);
    rd_chk(pio_pkg::OFF_EVT, 32'h0000000C, 32'h00000004);
    wb(1'b1, pio_pkg::OFF_EVT, 32'h00000004);
    wb(1'b1, pio_pkg::OFF_EVT, 32'h00000003);
    rd_chk(pio_pkg::OFF_EVT, 32'hFFFFFFFF, 32'h00000003);
    @(posedge core_clk);
    event_pin_n <= 2'b01;
    tick(3);
    rd_chk(pio_pkg::OFF_HWSTAT, 32'hFFFFFFFF, 32'h00004000);
    $display("test events done");
  endtask

  task automatic test_knob_unmapped;
    wb(1'b1, pio_pkg::OFF_OUT, 32'h0000FFFE);
    @(posedge core_clk);
    knob_sel <= 1'b1;
    knob_up <= 1'b1;
    repeat (3) @(posedge core_clk);
    knob_up <= 1'b0;
    knob_dn <= 1'b1;
    @(posedge core_clk);
    knob_dn <= 1'b0;
    knob_sel <= 1'b0;
    tick(2);
    rd_chk(pio_pkg::OFF_OUT, 32'hFFFFFFFF, 32'h00000000);
    wb(1'b1, 8'h40, 32'hA5A5A5A5);
    rd_chk(8'h40, 32'hFFFFFFFF, 32'h00000000);
    $display("test knob and unmapped done");
  endtask

  initial begin
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    test_reset();
    test_capture();
    test_send();
    test_events();
    test_knob_unmapped();
    complete_run();
  end
endmodule // test_parallel_io_interrupt_port
